/* rtl/tcil_defs.svh */
`ifndef TCIL_DEFS_SVH
`define TCIL_DEFS_SVH
// ****************************************
// register map
// ****************************************
`define TCIL_STATUS_OFS   8'h00
`define TCIL_DLY_ONE_OFS  8'h04
`define TCIL_DLY_MULTI_OFS 8'h08
`define TCIL_ELAPSED_OFS  8'h0C
`define TCIL_DLY_ONE_RST  16'h0064
`define TCIL_DLY_MULTI_RST 16'h0032
// ****************************************
// thresholds and timing
// ****************************************
`define TCIL_HALF_PCT     7'h32
`define TCIL_CLK_MHZ      100
`define TCIL_UV_DLY_MS    1
`define TCIL_UF_DLY_MS    1
`define TCIL_TICK_MS      1
`define TCIL_UV_DLY_CYC   (`TCIL_UV_DLY_MS * 1000 * `TCIL_CLK_MHZ)
`define TCIL_UF_DLY_CYC   (`TCIL_UF_DLY_MS * 1000 * `TCIL_CLK_MHZ)
`define TCIL_TICK_CYC     (`TCIL_TICK_MS * 1000 * `TCIL_CLK_MHZ)
`endif

/* rtl/tcil_pkg.sv */
`default_nettype none
package tcil_pkg;
  typedef enum logic [1:0] {
    TCIL_T_IDLE = 2'b00,
    TCIL_T_RUN  = 2'b01,
    TCIL_T_DONE = 2'b10
  } tcil_tmr_t;

  typedef struct packed {
    logic [15:0] pad;
    logic        p6;
    logic        p7;
    logic        p8;
    logic        p9;
    logic        p10;
    logic        sr_blk;
    logic [1:0]  ir_blk;
    logic [1:0]  prl_blk;
    logic        rx_trip;
    logic        brk_open;
    logic        md_afw;
    logic        td_afw;
    logic [1:0]  tmr;
  } tcil_stat_t;
endpackage
`default_nettype wire

/* rtl/tcil_top.sv */
// Overview of operation
// - low power block suppresses pump undervoltage trip
// - each undervoltage relay delayed before voting
// - two of four underfrequency: trip, open breakers
// - each underfrequency relay delayed before voting
// - one generator two-of-three low-low: trip, motor pumps
// - two or more generators: start turbine pump
// - level delay applies only below half power
// - low-low starts timer, limit from power, count
// - power rise shortens limit, elapsed time kept
// - falling power never lengthens the limit
// - turbine trip from oil or valves, above permissive
// - open contact or lost power means trip
// - safety injection always trips the reactor
// - manual switches trip both trains, never blocked
// - source range block needs intermediate permissive
// - both intermediate channels low restore source trip
// - reset switches re-enable; high power forces block
// - intermediate, low power-range block needs permissive
// - three of four low re-enable those trips
// - low power block conditions and blocked trips
// - single-loop flow permissive from three of four
// - turbine trip permissive from three of four
// - loop low flow two of three; loop voting
`timescale 1ns/1ps
`default_nettype none
`include "tcil_defs.svh"
module tcil_top #(
  parameter int UV_DLY_CYC = `TCIL_UV_DLY_CYC,
  parameter int UF_DLY_CYC = `TCIL_UF_DLY_CYC,
  parameter int TICK_CYC   = `TCIL_TICK_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // pump relays
  input  wire logic [3:0]  uv_relay,
  input  wire logic [3:0]  uf_relay,
  // process comparators
  input  wire logic [11:0] sg_lowlow,
  input  wire logic [11:0] flow_cmp,
  input  wire logic [3:0]  press_lo,
  input  wire logic [2:0]  level_hi,
  input  wire logic [6:0]  power_pct,
  // turbine contacts, high while closed
  input  wire logic [2:0]  oil_contact,
  input  wire logic [3:0]  valve_contact,
  // actuation and manual
  input  wire logic        si_actuate,
  input  wire logic [1:0]  manual_sw,
  // nuclear range trips and permissive sources
  input  wire logic [1:0]  sr_hi,
  input  wire logic [1:0]  ir_hi,
  input  wire logic [3:0]  prl_hi,
  input  wire logic [1:0]  ir_p6,
  input  wire logic [3:0]  flux_p10,
  input  wire logic [3:0]  flux_below_p7,
  input  wire logic [1:0]  imp_below_p7,
  input  wire logic [3:0]  flux_below_p8,
  input  wire logic [3:0]  flux_below_p9,
  // operator block and reset switches
  input  wire logic        sr_block_sw,
  input  wire logic [1:0]  sr_reset_sw,
  input  wire logic [1:0]  ir_block_sw,
  input  wire logic [1:0]  prl_block_sw,
  // trip outputs
  output logic             rx_trip,
  output logic [1:0]       uv_coil_hold,
  output logic [1:0]       shunt_coil,
  output logic             pump_brk_open,
  output logic             md_afw_start,
  output logic             td_afw_start
);
  // ****************************************
  // voting helpers
  // ****************************************
  function automatic logic [2:0] cnt4(input logic [3:0] v);
    return 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
  endfunction

  function automatic logic vote23(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  function automatic logic [2:0] band(input logic [6:0] p);
    return (p >= 7'h28) ? 3'h4 : (p >= 7'h1E) ? 3'h3 :
           (p >= 7'h14) ? 3'h2 : (p >= 7'h0A) ? 3'h1 : 3'h0;
  endfunction

  // ****************************************
  // permissives
  // ****************************************
  wire logic p7  = !((cnt4(flux_below_p7) >= 3'h3) && (&imp_below_p7));
  wire logic p8  = !(cnt4(flux_below_p8) >= 3'h3);
  wire logic p9  = !(cnt4(flux_below_p9) >= 3'h3);
  wire logic p6  = |ir_p6;
  wire logic p10 = cnt4(flux_p10) >= 3'h2;

  // ****************************************
  // relay delay filters
  // ****************************************
  logic [7:0] rly_in;
  logic [7:0] rly_dly;
  assign rly_in = {uf_relay, uv_relay};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_rly
      // short dips never reach the voter
      localparam int LIM = (gi < 4) ? UV_DLY_CYC : UF_DLY_CYC;
      logic [31:0] cnt_ff;
      wire logic [31:0] nxt_cnt = !rly_in[gi] ? 32'h0 :
                                  (cnt_ff < 32'(LIM)) ? cnt_ff + 32'h1 : cnt_ff;
      always_ff @(posedge clk) begin
        cnt_ff <= !rst_n ? 32'h0 : nxt_cnt;
      end
      assign rly_dly[gi] = rly_in[gi] && (cnt_ff >= 32'(LIM));
    end
  endgenerate

  // ****************************************
  // flow, pump and pressurizer trips
  // ****************************************
  logic [3:0] loop_lo;
  logic [3:0] sg_lo;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_loop
      assign loop_lo[gi] = vote23(flow_cmp[gi*3 +: 3]);
      assign sg_lo[gi]   = vote23(sg_lowlow[gi*3 +: 3]);
    end
  endgenerate

  wire logic flow_trip = p8 ? (|loop_lo) : (p7 && cnt4(loop_lo) >= 3'h2);
  wire logic uv_trip   = p7 && (cnt4(rly_dly[3:0]) >= 3'h2);
  wire logic uf_trip   = p7 && (cnt4(rly_dly[7:4]) >= 3'h2);
  wire logic lp_trip   = p7 && (cnt4(press_lo) >= 3'h2);
  wire logic hl_trip   = p7 && vote23(level_hi);

  // ****************************************
  // turbine trip, contacts open on demand
  // ****************************************
  wire logic tt_raw  = vote23(~oil_contact) || (&(~valve_contact));
  wire logic tt_trip = p9 && tt_raw;

  // ****************************************
  // level trip delay timer
  // ****************************************
  logic [15:0]          dly_one_ff;
  logic [15:0]          dly_multi_ff;
  logic [15:0]          lim_ff;
  logic [15:0]          el_ff;
  logic [31:0]          tick_ff;
  tcil_pkg::tcil_tmr_t  tmr_ff;
  tcil_pkg::tcil_tmr_t  nxt_tmr;

  wire logic [2:0]  nsg      = cnt4(sg_lo);
  wire logic        sg_any   = nsg != 3'h0;
  wire logic        sg_multi = nsg >= 3'h2;
  wire logic        half     = power_pct >= `TCIL_HALF_PCT;
  wire logic [15:0] new_lim  = (sg_multi ? dly_multi_ff : dly_one_ff) >> band(power_pct);
  // limit may only shrink while running
  wire logic [15:0] nxt_lim  = (tmr_ff == tcil_pkg::TCIL_T_IDLE) ? new_lim :
                               (new_lim < lim_ff) ? new_lim : lim_ff;
  wire logic        tick     = tick_ff >= 32'(TICK_CYC - 1);
  wire logic [15:0] nxt_el   = (tmr_ff == tcil_pkg::TCIL_T_IDLE) ? 16'h0000 :
                               (tick && el_ff != 16'hFFFF) ? el_ff + 16'h0001 : el_ff;

  always_comb begin
    nxt_tmr = tmr_ff;
    unique case (tmr_ff)
      tcil_pkg::TCIL_T_IDLE: if (sg_any) nxt_tmr = tcil_pkg::TCIL_T_RUN;
      tcil_pkg::TCIL_T_RUN: begin
        if (!sg_any) nxt_tmr = tcil_pkg::TCIL_T_IDLE;
        else if (el_ff >= lim_ff) nxt_tmr = tcil_pkg::TCIL_T_DONE;
      end
      tcil_pkg::TCIL_T_DONE: if (!sg_any) nxt_tmr = tcil_pkg::TCIL_T_IDLE;
      default: nxt_tmr = tcil_pkg::TCIL_T_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tmr_ff  <= tcil_pkg::TCIL_T_IDLE;
      lim_ff  <= 16'h0000;
      el_ff   <= 16'h0000;
      tick_ff <= 32'h0;
    end else begin
      tmr_ff  <= nxt_tmr;
      lim_ff  <= nxt_lim;
      el_ff   <= nxt_el;
      tick_ff <= (tick || tmr_ff == tcil_pkg::TCIL_T_IDLE) ? 32'h0 : tick_ff + 32'h1;
    end
  end

  // no delay at or above half power
  wire logic sg_go = sg_any && (half || tmr_ff == tcil_pkg::TCIL_T_DONE);

  // ****************************************
  // range blocks
  // ****************************************
  logic       sr_blk_ff;
  logic [1:0] ir_blk_ff;
  logic [1:0] prl_blk_ff;

  wire logic nxt_sr_blk = p10 ? 1'b1 :
                          !p6 ? 1'b0 :
                          (|sr_reset_sw) ? 1'b0 :
                          (sr_block_sw ? 1'b1 : sr_blk_ff);
  wire logic [1:0] nxt_ir_blk  = p10 ? (ir_blk_ff | ir_block_sw) : 2'b00;
  wire logic [1:0] nxt_prl_blk = p10 ? (prl_blk_ff | prl_block_sw) : 2'b00;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sr_blk_ff  <= 1'b0;
      ir_blk_ff  <= 2'b00;
      prl_blk_ff <= 2'b00;
    end else begin
      sr_blk_ff  <= nxt_sr_blk;
      ir_blk_ff  <= nxt_ir_blk;
      prl_blk_ff <= nxt_prl_blk;
    end
  end

  // ****************************************
  // train trip outputs
  // ****************************************
  wire logic com_trip = uv_trip || uf_trip || flow_trip || lp_trip || hl_trip ||
                        sg_go || tt_trip || si_actuate;
  wire logic man      = |manual_sw;
  wire logic sr_trip  = !sr_blk_ff && (|sr_hi);
  logic [1:0] train_trip;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_train
      // manual path bypasses every block
      assign train_trip[gi] = man || com_trip || sr_trip ||
                              (!ir_blk_ff[gi] && (|ir_hi)) ||
                              (!prl_blk_ff[gi] && cnt4(prl_hi) >= 3'h2);
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_trip       <= 1'b0;
      uv_coil_hold  <= 2'b11;
      shunt_coil    <= 2'b00;
      pump_brk_open <= 1'b0;
      md_afw_start  <= 1'b0;
      td_afw_start  <= 1'b0;
    end else begin
      rx_trip       <= |train_trip;
      uv_coil_hold  <= ~train_trip;
      shunt_coil    <= train_trip;
      pump_brk_open <= uf_trip;
      md_afw_start  <= sg_go;
      td_afw_start  <= sg_go && sg_multi;
    end
  end

  // ****************************************
  // ahb-lite register slave
  // ****************************************
  logic       wr_pend_ff;
  logic [7:0] wa_ff;
  tcil_pkg::tcil_stat_t stat;
  assign stat = '{pad: 16'h0000, p6: p6, p7: p7, p8: p8, p9: p9, p10: p10,
                  sr_blk: sr_blk_ff, ir_blk: ir_blk_ff, prl_blk: prl_blk_ff,
                  rx_trip: rx_trip, brk_open: pump_brk_open, md_afw: md_afw_start,
                  td_afw: td_afw_start, tmr: tmr_ff};

  wire logic        acc   = hsel && htrans[1] && hready;
  // unmapped offsets read zero, writes dropped
  wire logic [31:0] rd_mux = (haddr == `TCIL_STATUS_OFS)    ? 32'(stat) :
                             (haddr == `TCIL_DLY_ONE_OFS)   ? {16'h0000, dly_one_ff} :
                             (haddr == `TCIL_DLY_MULTI_OFS) ? {16'h0000, dly_multi_ff} :
                             (haddr == `TCIL_ELAPSED_OFS)   ? {16'h0000, el_ff} : 32'h0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_pend_ff   <= 1'b0;
      wa_ff        <= 8'h00;
      hrdata       <= 32'h0;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      dly_one_ff   <= `TCIL_DLY_ONE_RST;
      dly_multi_ff <= `TCIL_DLY_MULTI_RST;
    end else begin
      wr_pend_ff <= acc && hwrite;
      wa_ff      <= haddr;
      hrdata     <= (acc && !hwrite) ? rd_mux : 32'h0;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      if (wr_pend_ff && wa_ff == `TCIL_DLY_ONE_OFS) dly_one_ff <= hwdata[15:0];
      if (wr_pend_ff && wa_ff == `TCIL_DLY_MULTI_OFS) dly_multi_ff <= hwdata[15:0];
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_manual_trip: assert property (man |=> shunt_coil == 2'b11 && uv_coil_hold == 2'b00)
    else $error("manual switch did not trip both trains");
  a_si_trip: assert property (si_actuate |=> rx_trip)
    else $error("safety injection did not trip");
  a_uv_block: assert property (!p7 |-> !uv_trip)
    else $error("undervoltage trip below low power block");
  a_uv_delay: assert property ($rose(uv_relay[0]) |-> !rly_dly[0])
    else $error("undervoltage relay passed undelayed");
  a_uf_breaker: assert property (uf_trip |=> pump_brk_open && rx_trip)
    else $error("underfrequency did not open breakers");
  a_lim_shrink: assert property (tmr_ff != tcil_pkg::TCIL_T_IDLE &&
    $past(tmr_ff) != tcil_pkg::TCIL_T_IDLE |-> lim_ff <= $past(lim_ff))
    else $error("delay limit grew while running");
  a_el_keep: assert property (tmr_ff != tcil_pkg::TCIL_T_IDLE &&
    $past(tmr_ff) != tcil_pkg::TCIL_T_IDLE |-> el_ff >= $past(el_ff))
    else $error("elapsed time restarted while running");
  a_sr_force: assert property (p10 |=> sr_blk_ff)
    else $error("source block not forced");
  a_sr_auto: assert property (!p6 && !p10 |=> !sr_blk_ff)
    else $error("source trip not restored");
  a_ir_auto: assert property (!p10 |=> ir_blk_ff == 2'b00 && prl_blk_ff == 2'b00)
    else $error("range blocks not cleared");
  a_tt_gate: assert property (!p9 |-> !tt_trip)
    else $error("turbine trip passed below permissive");
  a_td_pump: assert property (sg_go && sg_multi |=> td_afw_start && md_afw_start)
    else $error("turbine pump not started");

  a_uv_trip: assert property (p7 && cnt4(rly_dly[3:0]) >= 3'h2 |=> rx_trip)
    else $error("voted undervoltage did not trip");
  a_uf_delay: assert property ($rose(uf_relay[0]) |-> !rly_dly[4])
    else $error("underfrequency relay passed undelayed");
  a_sg_start: assert property (sg_any && half |=> md_afw_start && rx_trip)
    else $error("level trip not immediate at half power");
  a_sg_wait: assert property (sg_any && !half &&
    tmr_ff != tcil_pkg::TCIL_T_DONE |=> !md_afw_start)
    else $error("level trip not delayed below half power");
  a_tt_trip: assert property (p9 &&
    (vote23(~oil_contact) || valve_contact == 4'h0) |=> rx_trip)
    else $error("turbine trip did not trip reactor");
  a_sr_accept: assert property (p6 && !p10 && sr_block_sw &&
    sr_reset_sw == 2'h0 |=> sr_blk_ff)
    else $error("source block refused with permissive");
  a_sr_reset: assert property (p6 && !p10 && sr_reset_sw != 2'h0 |=> !sr_blk_ff)
    else $error("source reset switch ignored");
  a_ir_block: assert property (p10 && ir_block_sw[0] |=> ir_blk_ff[0])
    else $error("intermediate block refused with permissive");
  a_prl_block: assert property (p10 && prl_block_sw[1] |=> prl_blk_ff[1])
    else $error("power range block refused with permissive");
  a_flow_one: assert property (p8 && loop_lo != 4'h0 |=> rx_trip)
    else $error("single loop low flow did not trip");
  a_flow_two: assert property (p7 && cnt4(loop_lo) >= 3'h2 |=> rx_trip)
    else $error("two loop low flow did not trip");

  c_manual: cover property (man ##1 rx_trip);
  c_sg_delayed: cover property (tmr_ff == tcil_pkg::TCIL_T_RUN ##1
    tmr_ff == tcil_pkg::TCIL_T_DONE);
  c_sr_block: cover property (!sr_blk_ff ##1 sr_blk_ff && !p10);
  c_td_pump: cover property (sg_multi && !half ##1 td_afw_start);
  c_ir_block: cover property (!ir_blk_ff[0] ##1 ir_blk_ff[0]);
endmodule
`default_nettype wire

/* testbench/tcil_plant.sv */
`timescale 1ns/1ps
`default_nettype none
module tcil_plant (
  // turbine trip demands
  input  wire logic [2:0] oil_low,
  input  wire logic [3:0] valve_shut,
  // contact loop supply
  input  wire logic       contact_pwr,
  // contacts as seen by the protection logic
  output logic [2:0]      oil_contact,
  output logic [3:0]      valve_contact
);
  // ****************************************
  // contacts
  // ****************************************
  // a dead supply reads like every contact open, never like a closed one
  assign oil_contact   = contact_pwr ? ~oil_low : 3'h0;
  assign valve_contact = contact_pwr ? ~valve_shut : 4'h0;
endmodule
`default_nettype wire

/* testbench/trip_coincidence_interlock_logic_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module trip_coincidence_interlock_logic_tb;
  logic clk, rst_n, hsel, hwrite, si_actuate, sr_block_sw, contact_pwr;
  logic rx_trip, hreadyout, hresp, pump_brk_open, md_afw_start, td_afw_start;
  logic [1:0]  htrans, manual_sw, sr_hi, ir_hi, ir_p6, imp_below_p7, sr_reset_sw;
  logic [1:0]  ir_block_sw, prl_block_sw, uv_coil_hold, shunt_coil;
  logic [2:0]  oil_low, oil_contact, level_hi;
  logic [3:0]  uv_relay, uf_relay, press_lo, prl_hi, flux_p10, valve_shut, valve_contact;
  logic [3:0]  flux_below_p7, flux_below_p8, flux_below_p9;
  logic [6:0]  power_pct;
  logic [7:0]  haddr;
  logic [11:0] sg_lowlow, flow_cmp;
  logic [31:0] hwdata, hrdata, rd, r;
  int          error_cnt, total_checks, seed, n, c;
  tcil_pkg::tcil_stat_t st;

  tcil_top #(.UV_DLY_CYC(4), .UF_DLY_CYC(4), .TICK_CYC(2)) u_dut (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .uv_relay(uv_relay), .uf_relay(uf_relay),
    .sg_lowlow(sg_lowlow), .flow_cmp(flow_cmp), .press_lo(press_lo), .level_hi(level_hi),
    .power_pct(power_pct), .oil_contact(oil_contact), .valve_contact(valve_contact),
    .si_actuate(si_actuate), .manual_sw(manual_sw), .sr_hi(sr_hi), .ir_hi(ir_hi),
    .prl_hi(prl_hi), .ir_p6(ir_p6), .flux_p10(flux_p10), .flux_below_p7(flux_below_p7),
    .imp_below_p7(imp_below_p7), .flux_below_p8(flux_below_p8),
    .flux_below_p9(flux_below_p9), .sr_block_sw(sr_block_sw), .sr_reset_sw(sr_reset_sw),
    .ir_block_sw(ir_block_sw), .prl_block_sw(prl_block_sw), .rx_trip(rx_trip),
    .uv_coil_hold(uv_coil_hold), .shunt_coil(shunt_coil), .pump_brk_open(pump_brk_open),
    .md_afw_start(md_afw_start), .td_afw_start(td_afw_start));

  tcil_plant u_plant (.oil_low(oil_low), .valve_shut(valve_shut), .contact_pwr(contact_pwr),
    .oil_contact(oil_contact), .valve_contact(valve_contact));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
    rd = hrdata;
    check("okay response", 32'h0, {31'h0, hresp});
    hsel <= 1'h0;
  endtask
  // outputs as one nibble: trip, breakers, motor pumps, turbine pump
  task automatic expect4(input string what, input logic [3:0] exp, input int k);
    cyc(k);
    check(what, exp, {rx_trip, pump_brk_open, md_afw_start, td_afw_start});
  endtask
  task automatic quiet();
    {uv_relay, uf_relay, press_lo, prl_hi, flux_p10, valve_shut} <= 24'h0;
    {flux_below_p7, flux_below_p8, flux_below_p9, sg_lowlow, flow_cmp} <= 36'h0;
    {level_hi, oil_low, si_actuate, sr_block_sw} <= 8'h0;
    {manual_sw, sr_hi, ir_hi, ir_p6, imp_below_p7, sr_reset_sw, ir_block_sw} <= 14'h0;
    prl_block_sw <= 2'h0;
    contact_pwr <= 1'h1;
    power_pct <= 7'h3C;
    cyc(4);
  endtask
  task automatic time_trip();
    c = 0;
    while (rx_trip !== 1'h1 && c < 400) begin
      @(posedge clk);
      c++;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // a hung handshake or timer must still end the run
  initial begin
    #300000;
    error_cnt++;
    $display("[ERR] watchdog expired");
    report_and_stop();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 32'h850F5E04;
    {error_cnt, total_checks} = 0;
    {rst_n, hsel, hwrite, htrans, haddr, hwdata} = 0;
    quiet();
    cyc(2);
    rst_n <= 1'h1;
    check("coils at reset", 4'hC, {uv_coil_hold, shunt_coil});
    ahb(1'h0, 8'h04, 32'h0);
    check("dly one reset", 32'h64, rd);
    ahb(1'h0, 8'h08, 32'h0);
    check("dly multi reset", 32'h32, rd);
    ahb(1'h1, 8'h20, 32'hFFFF);
    ahb(1'h0, 8'h20, 32'h0);
    check("unmapped read", 32'h0, rd);
    for (n = 0; n < 6; n++) begin
      r = $random(seed);
      ahb(1'h1, 8'h08, r);
      ahb(1'h0, 8'h08, 32'h0);
      check("dly multi rw", {16'h0, r[15:0]}, rd);
    end
    // manual trip cannot be held off by any interlock state
    for (n = 0; n < 8; n++) begin
      r = $random(seed);
      manual_sw <= (r[1:0] == 2'h0) ? 2'h2 : r[1:0];
      {flux_below_p7, imp_below_p7, flux_below_p9, power_pct} <= r[23:7];
      cyc(3);
      check("manual trip", 5'h13, {rx_trip, uv_coil_hold, shunt_coil});
    end
    quiet();
    si_actuate <= 1'h1;
    expect4("si trip", 4'h8, 3);
    quiet();
    uv_relay <= 4'hF;
    cyc(3);
    uv_relay <= 4'h0;
    expect4("uv dip", 4'h0, 8);
    {flux_below_p7, imp_below_p7, uv_relay} <= 10'h3FF;
    expect4("uv below p7", 4'h0, 12);
    {flux_below_p7, imp_below_p7} <= 6'h0;
    cyc(12);
    check("uv trip", 1'h1, rx_trip);
    quiet();
    uf_relay <= 4'h3;
    cyc(3);
    uf_relay <= 4'h1;
    expect4("uf one pump", 4'h0, 12);
    uf_relay <= 4'h3;
    expect4("uf two pumps", 4'hC, 12);
    {flux_below_p7, imp_below_p7} <= 6'h3F;
    expect4("uf below p7", 4'h0, 4);
    quiet();
    {flux_below_p7, imp_below_p7, press_lo} <= 10'h1D3;
    expect4("one impulse low", 4'h8, 3);
    {imp_below_p7, level_hi} <= 5'h1B;
    expect4("press level blocked", 4'h0, 3);
    quiet();
    flow_cmp <= 12'h003;
    expect4("one loop p8", 4'h8, 3);
    flux_below_p8 <= 4'hE;
    expect4("one loop no p8", 4'h0, 3);
    flow_cmp <= 12'h01B;
    expect4("two loops", 4'h8, 3);
    {flux_below_p7, imp_below_p7} <= 6'h3F;
    expect4("loops below p7", 4'h0, 3);
    quiet();
    oil_low <= 3'h3;
    expect4("oil two", 4'h8, 3);
    flux_below_p9 <= 4'h7;
    expect4("oil below p9", 4'h0, 3);
    {flux_below_p9, oil_low, valve_shut} <= 11'h00E;
    expect4("three valves", 4'h0, 3);
    valve_shut <= 4'hF;
    expect4("four valves", 4'h8, 3);
    {valve_shut, contact_pwr} <= 5'h0;
    expect4("contact supply lost", 4'h8, 3);
    // ****************************************
    // range blocks
    // ****************************************
    quiet();
    {sr_block_sw, sr_hi} <= 3'h5;
    expect4("sr block refused", 4'h8, 3);
    ir_p6 <= 2'h1;
    expect4("sr blocked", 4'h0, 3);
    sr_block_sw <= 1'h0;
    sr_reset_sw <= 2'h2;
    expect4("sr reset", 4'h8, 3);
    {sr_reset_sw, sr_block_sw} <= 3'h1;
    cyc(2);
    {sr_reset_sw, sr_block_sw, flux_p10} <= 7'h23;
    expect4("sr forced at p10", 4'h0, 3);
    {flux_p10, ir_p6, sr_reset_sw} <= 8'h0;
    expect4("sr restored", 4'h8, 3);
    quiet();
    {ir_hi, ir_block_sw, flux_p10} <= 8'h71;
    expect4("ir block refused", 4'h8, 3);
    {ir_block_sw, flux_p10, prl_hi} <= 10'h333;
    prl_block_sw <= 2'h3;
    expect4("ir blocked", 4'h0, 3);
    ahb(1'h0, 8'h00, 32'h0);
    st = rd;
    check("ir block status", 2'h3, st.ir_blk);
    check("prl block status", 2'h3, st.prl_blk);
    {ir_block_sw, flux_p10} <= 6'h31;
    expect4("ir restored", 4'h8, 3);
    // ****************************************
    // level trip delay
    // ****************************************
    quiet();
    ahb(1'h1, 8'h04, 32'h40);
    ahb(1'h1, 8'h08, 32'h10);
    sg_lowlow <= 12'h003;
    time_trip();
    check("no delay at half", 1'h1, c <= 3);
    expect4("one generator", 4'hA, 0);
    sg_lowlow <= 12'h01B;
    expect4("two generators", 4'hB, 3);
    {sg_lowlow, power_pct} <= 19'h5;
    cyc(4);
    sg_lowlow <= 12'h01B;
    time_trip();
    check("multi delay", 1'h1, c >= 30 && c <= 38);
    sg_lowlow <= 12'h0;
    cyc(4);
    sg_lowlow <= 12'h003;
    expect4("delayed low power", 4'h0, 40);
    power_pct <= 7'h2D;
    time_trip();
    check("power rise", 1'h1, c <= 6);
    {sg_lowlow, power_pct} <= 19'h19;
    cyc(4);
    sg_lowlow <= 12'h003;
    cyc(4);
    power_pct <= 7'h5;
    time_trip();
    check("power fall", 1'h1, c >= 26 && c <= 34);
    report_and_stop();
  end
endmodule
`default_nettype wire
